/* hw/dot_display_pkg.sv */
package dot_display_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // System clock and display timebase.
  localparam int CLK_PERIOD_NS = 50;
  localparam int OSC_PERIOD_NS = 17500;
  localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FLASH_PERIOD_TICKS = 28672;
  localparam int SELFTEST_TICKS = 262144;
  localparam int CLEAR_TICKS = 3;
  localparam int INIT_TICKS = 3;
  localparam int ROM_DEPTH = 128;
  localparam int ROM_AW = 7;
  localparam int CHECKSUM_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Area select on {A4, A3} while the flash-space select is high.
  localparam logic [1:0] AREA_PTR = 2'h0;
  localparam logic [1:0] AREA_GLYPH = 2'h1;
  localparam logic [1:0] AREA_CTRL = 2'h2;
  localparam logic [1:0] AREA_CHAR = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Control word layout and reset values.
  localparam int CW_BRIGHT_LSB = 0;
  localparam int CW_BRIGHT_MSB = 2;
  localparam int CW_FLASH_BIT = 3;
  localparam int CW_BLINK_BIT = 4;
  localparam int CW_PASS_BIT = 5;
  localparam int CW_TEST_BIT = 6;
  localparam int CW_CLEAR_BIT = 7;
  localparam logic [7:0] CW_RESET = 8'h00;
  localparam logic [7:0] CW_PASS_MASK = 8'h20;
  localparam logic [2:0] BRIGHT_BLANK = 3'h7;
  localparam logic [7:0] BLANK_CHAR = 8'h20;
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam logic [3:0] PTR_AFTER_TEST = 4'hF;
  localparam int GLYPHS = 16;
  localparam int GLYPH_ROWS = 7;
  localparam int DIGITS = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Host bus pins as one bundle.
  typedef struct packed {
    logic ce_n;
    logic wr_n;
    logic rd_n;
    logic blink_space_select_n;
    logic [4:0] addr;
    logic [7:0] data;
  } host_bus_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CLEAR = 2'h1,
    ST_TEST = 2'h2
  } seq_state_t;

endpackage : dot_display_pkg

/* hw/display_timebase.sv */
`timescale 1ns/1ps
module display_timebase #(
  parameter int OSC_DIV = dot_display_pkg::OSC_DIV,
  parameter int FLASH_PERIOD_TICKS = dot_display_pkg::FLASH_PERIOD_TICKS
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Clock pin
  input wire logic clock_source_select_i,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_o,
  // Timebase
  output logic tick_o,
  output logic flash_phase_o,
  output logic [2:0] pwm_phase_o
);
  localparam int OW = $clog2(OSC_DIV + 1);
  localparam int FW = $clog2(FLASH_PERIOD_TICKS + 1);
  localparam logic [OW-1:0] OSC_HALF = OW'(OSC_DIV / 2 - 1);
  localparam logic [FW-1:0] FL_HALF = FW'(FLASH_PERIOD_TICKS / 2 - 1);
  localparam logic [FW-1:0] FL_LAST = FW'(FLASH_PERIOD_TICKS - 1);

  logic [OW-1:0] osc_cnt_reg;
  logic osc_reg;
  logic ext_prev_reg;
  logic [FW-1:0] fl_cnt_reg;
  wire osc_wrap = (osc_cnt_reg == OSC_HALF);
  wire int_tick = osc_wrap & ~osc_reg;
  wire ext_tick = clk_pin_i & ~ext_prev_reg;
  wire tick_next = clock_source_select_i ? int_tick : ext_tick;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_cnt_reg <= '0;
      osc_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      clk_pin_o <= 1'b0;
      clk_pin_oe_o <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      osc_cnt_reg <= osc_wrap ? '0 : osc_cnt_reg + 1'b1;
      osc_reg <= osc_wrap ? ~osc_reg : osc_reg;
      ext_prev_reg <= clk_pin_i;
      clk_pin_o <= osc_reg;
      clk_pin_oe_o <= clock_source_select_i;
      tick_o <= tick_next;
    end
  end

  // Counters restart on reset so that displays reset together stay in step.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fl_cnt_reg <= '0;
      flash_phase_o <= 1'b0;
      pwm_phase_o <= 3'h0;
    end else if (tick_o) begin
      fl_cnt_reg <= (fl_cnt_reg == FL_LAST) ? '0 : fl_cnt_reg + 1'b1;
      if (fl_cnt_reg == FL_HALF || fl_cnt_reg == FL_LAST) begin
        flash_phase_o <= ~flash_phase_o;
      end
      pwm_phase_o <= pwm_phase_o + 3'h1;
    end
  end

  property p_tick_single;
    @(posedge core_clk_i) disable iff (!resetn_i) tick_o |=> !tick_o;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("Display tick lasted two cycles.");

  property p_phase_on_tick;
    @(posedge core_clk_i) disable iff (!resetn_i) !$stable(flash_phase_o) |-> $past(tick_o);
  endproperty
  a_phase_on_tick: assert property (p_phase_on_tick) else $error("Flash phase moved without a tick.");

endmodule : display_timebase

/* hw/dot_display_core.sv */
`timescale 1ns/1ps
module dot_display_core #(
  parameter int OSC_DIV = dot_display_pkg::OSC_DIV,
  parameter int FLASH_PERIOD_TICKS = dot_display_pkg::FLASH_PERIOD_TICKS,
  parameter int SELFTEST_TICKS = dot_display_pkg::SELFTEST_TICKS,
  // Arbitrary value; set to the sum of the real font contents.
  parameter logic [15:0] CHECKSUM_EXPECT = 16'h1234
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Host bus
  input wire dot_display_pkg::host_bus_t bus_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // Clock pin
  input wire logic clock_source_select_i,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_o,
  // Character ROM used by the self test
  output logic [6:0] rom_addr_o,
  input wire logic [7:0] rom_data_i,
  // Display multiplexer side
  input wire logic [2:0] char_sel_i,
  output logic [7:0] char_o,
  input wire logic [3:0] glyph_sel_i,
  input wire logic [2:0] glyph_row_sel_i,
  output logic [4:0] glyph_row_o,
  output logic [2:0] brightness_o,
  output logic [7:0] digit_lit_o,
  output logic test_active_o,
  output logic test_pattern_o,
  output logic busy_o
);
  localparam int CW = $clog2(SELFTEST_TICKS + 1);
  localparam int GW = dot_display_pkg::GLYPHS * dot_display_pkg::GLYPH_ROWS;
  localparam logic [CW-1:0] TEST_LAST = CW'(SELFTEST_TICKS - 1);
  localparam logic [CW-1:0] CLEAR_LAST = CW'(dot_display_pkg::CLEAR_TICKS - 1);
  localparam logic [CW-1:0] ROM_END = CW'(dot_display_pkg::ROM_DEPTH);
  localparam logic [1:0] INIT_DONE = 2'(dot_display_pkg::INIT_TICKS);

  ////////////////////////////////////////////////////////////////////////////
  // Timebase.
  logic tick;
  logic flash_phase;
  logic [2:0] pwm_phase;

  display_timebase #(
    .OSC_DIV(OSC_DIV),
    .FLASH_PERIOD_TICKS(FLASH_PERIOD_TICKS)
  ) u_timebase (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .clock_source_select_i(clock_source_select_i),
    .clk_pin_i(clk_pin_i),
    .clk_pin_o(clk_pin_o),
    .clk_pin_oe_o(clk_pin_oe_o),
    .tick_o(tick),
    .flash_phase_o(flash_phase),
    .pwm_phase_o(pwm_phase)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State.
  logic [3:0] ptr_reg;
  logic [4:0] glyph_mem_reg [0:GW-1];
  logic [7:0] char_reg [0:7];
  logic [7:0] flash_reg;
  logic [7:0] ctrl_reg;
  logic wr_prev_n_reg;
  dot_display_pkg::seq_state_t seq_reg;
  dot_display_pkg::seq_state_t seq_next;
  logic [CW-1:0] seq_cnt_reg;
  logic [15:0] sum_reg;
  logic [1:0] init_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  wire [1:0] area = bus_i.addr[4:3];
  wire [2:0] row = bus_i.addr[2:0];
  wire sel_high = bus_i.blink_space_select_n;
  wire idle = (seq_reg == dot_display_pkg::ST_IDLE);
  // Rising edge of the write strobe with chip enable held low.
  wire wr_edge = ~wr_prev_n_reg & bus_i.wr_n & ~bus_i.ce_n & idle;
  wire rd_cycle = ~bus_i.ce_n & ~bus_i.rd_n & bus_i.wr_n;
  wire wr_flash = wr_edge & ~sel_high;
  wire wr_ptr = wr_edge & sel_high & (area == dot_display_pkg::AREA_PTR);
  wire wr_glyph = wr_edge & sel_high & (area == dot_display_pkg::AREA_GLYPH);
  wire wr_ctrl = wr_edge & sel_high & (area == dot_display_pkg::AREA_CTRL);
  wire wr_char = wr_edge & sel_high & (area == dot_display_pkg::AREA_CHAR);
  // Seven rows per glyph; row code 7 has no storage and reads as zero.
  wire row_ok = (row != 3'h7);
  wire [6:0] glyph_idx = 7'({3'h0, ptr_reg} * 7'd7 + {4'h0, row});
  wire [6:0] disp_idx = 7'({3'h0, glyph_sel_i} * 7'd7 + {4'h0, glyph_row_sel_i});
  wire [4:0] glyph_rd = row_ok ? glyph_mem_reg[glyph_idx] : 5'h00;
  wire start_test = wr_ctrl & bus_i.data[dot_display_pkg::CW_TEST_BIT];
  wire start_clear = wr_ctrl & bus_i.data[dot_display_pkg::CW_CLEAR_BIT];
  wire test_done = (seq_reg == dot_display_pkg::ST_TEST) & tick & (seq_cnt_reg == TEST_LAST);
  wire clear_done = (seq_reg == dot_display_pkg::ST_CLEAR) & tick & (seq_cnt_reg == CLEAR_LAST);
  wire fill_blank = test_done | clear_done;
  wire test_pass = (sum_reg == CHECKSUM_EXPECT);

  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    if (!sel_high) begin
      rd_data = {7'h00, flash_reg[row]};
    end else begin
      case (area)
        dot_display_pkg::AREA_PTR: rd_data = {4'h0, ptr_reg};
        dot_display_pkg::AREA_GLYPH: rd_data = {3'h0, glyph_rd};
        dot_display_pkg::AREA_CTRL: rd_data = ctrl_reg;
        dot_display_pkg::AREA_CHAR: rd_data = char_reg[row];
        default: rd_data = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear and self-test sequencer.
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      dot_display_pkg::ST_IDLE: begin
        if (start_test) begin
          seq_next = dot_display_pkg::ST_TEST;
        end else if (start_clear) begin
          seq_next = dot_display_pkg::ST_CLEAR;
        end
      end
      dot_display_pkg::ST_CLEAR: seq_next = clear_done ? dot_display_pkg::ST_IDLE : seq_reg;
      dot_display_pkg::ST_TEST: seq_next = test_done ? dot_display_pkg::ST_IDLE : seq_reg;
      default: seq_next = dot_display_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq_reg <= dot_display_pkg::ST_IDLE;
      seq_cnt_reg <= '0;
      wr_prev_n_reg <= 1'b1;
      init_cnt_reg <= 2'h0;
    end else begin
      seq_reg <= seq_next;
      wr_prev_n_reg <= bus_i.wr_n;
      if (seq_next != seq_reg) begin
        seq_cnt_reg <= '0;
      end else if (tick && !idle) begin
        seq_cnt_reg <= seq_cnt_reg + 1'b1;
      end
      if (tick && init_cnt_reg != INIT_DONE) begin
        init_cnt_reg <= init_cnt_reg + 2'h1;
      end
    end
  end

  // The ROM address runs one tick ahead of the sum, so a plain lookup ROM fits.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sum_reg <= 16'h0000;
      rom_addr_o <= 7'h00;
    end else if (start_test) begin
      sum_reg <= 16'h0000;
      rom_addr_o <= 7'h00;
    end else if (tick && seq_reg == dot_display_pkg::ST_TEST) begin
      rom_addr_o <= seq_cnt_reg[6:0];
      if (seq_cnt_reg != '0 && seq_cnt_reg <= ROM_END) begin
        sum_reg <= {sum_reg[14:0], sum_reg[15]} + {8'h00, rom_data_i};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers reached from the bus.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_reg <= dot_display_pkg::PTR_RESET;
      ctrl_reg <= dot_display_pkg::CW_RESET;
    end else if (test_done) begin
      ptr_reg <= dot_display_pkg::PTR_AFTER_TEST;
      ctrl_reg <= test_pass ? dot_display_pkg::CW_PASS_MASK : 8'h00;
    end else begin
      if (wr_ptr) begin
        ptr_reg <= bus_i.data[3:0];
      end
      if (clear_done) begin
        ctrl_reg[dot_display_pkg::CW_CLEAR_BIT] <= 1'b0;
      end else if (wr_ctrl) begin
        // Pass flag is kept; software cannot fake a passed test.
        ctrl_reg <= (bus_i.data & ~dot_display_pkg::CW_PASS_MASK) | (ctrl_reg & dot_display_pkg::CW_PASS_MASK);
      end
    end
  end

  // Glyph rows have no reset; they power up undefined like the real array.
  always_ff @(posedge core_clk_i) begin
    if (wr_glyph && row_ok) begin
      glyph_mem_reg[glyph_idx] <= bus_i.data[4:0];
    end
  end

  genvar d;
  generate
    for (d = 0; d < dot_display_pkg::DIGITS; d++) begin : g_digit
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          char_reg[d] <= dot_display_pkg::BLANK_CHAR;
          flash_reg[d] <= 1'b0;
        end else if (fill_blank) begin
          char_reg[d] <= dot_display_pkg::BLANK_CHAR;
          flash_reg[d] <= 1'b0;
        end else begin
          if (wr_char && row == 3'(d)) begin
            char_reg[d] <= bus_i.data;
          end
          if (wr_flash && row == 3'(d)) begin
            flash_reg[d] <= bus_i.data[0];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Display attributes.
  wire [2:0] bright = ctrl_reg[dot_display_pkg::CW_BRIGHT_MSB:dot_display_pkg::CW_BRIGHT_LSB];
  wire blink_en = ctrl_reg[dot_display_pkg::CW_BLINK_BIT];
  wire flash_en = ctrl_reg[dot_display_pkg::CW_FLASH_BIT];
  wire testing = (seq_reg == dot_display_pkg::ST_TEST);
  // Column drive is on for 8 - code slots out of 8; the blank code forces it off.
  wire col_on = (bright != dot_display_pkg::BRIGHT_BLANK) & (({1'b0, pwm_phase} + {1'b0, bright}) < 4'h8);
  wire blink_off = blink_en & flash_phase;
  wire flash_off = ~blink_en & flash_en & flash_phase;
  wire [7:0] lit_next = testing ? 8'hFF : ({8{col_on & ~blink_off}} & ~({8{flash_off}} & flash_reg));

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
      char_o <= dot_display_pkg::BLANK_CHAR;
      glyph_row_o <= 5'h00;
      brightness_o <= 3'h0;
      digit_lit_o <= 8'h00;
      test_active_o <= 1'b0;
      test_pattern_o <= 1'b0;
      busy_o <= 1'b1;
    end else begin
      data_o <= rd_cycle ? rd_data : 8'h00;
      data_oe_o <= rd_cycle;
      char_o <= char_reg[char_sel_i];
      glyph_row_o <= (glyph_row_sel_i != 3'h7) ? glyph_mem_reg[disp_idx] : 5'h00;
      brightness_o <= bright;
      digit_lit_o <= lit_next;
      test_active_o <= testing;
      test_pattern_o <= testing & seq_cnt_reg[CW-2];
      busy_o <= ~idle | (init_cnt_reg != INIT_DONE) | (seq_next != dot_display_pkg::ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_ptr_write;
    @(posedge core_clk_i) disable iff (!resetn_i) wr_ptr |=> ptr_reg == $past(bus_i.data[3:0]);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("Glyph pointer missed a write.");

  property p_flash_write;
    @(posedge core_clk_i) disable iff (!resetn_i) (wr_flash && !fill_blank) |=> flash_reg[$past(row)] == $past(bus_i.data[0]);
  endproperty
  a_flash_write: assert property (p_flash_write) else $error("Flash flag missed a write.");

  property p_pass_kept;
    @(posedge core_clk_i) disable iff (!resetn_i) (wr_ctrl && !test_done) |=> $stable(ctrl_reg[dot_display_pkg::CW_PASS_BIT]);
  endproperty
  a_pass_kept: assert property (p_pass_kept) else $error("Pass flag changed by a host write.");

  property p_clear_len;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (seq_reg == dot_display_pkg::ST_CLEAR) |-> (seq_cnt_reg <= CLEAR_LAST) && ctrl_reg[dot_display_pkg::CW_CLEAR_BIT];
  endproperty
  a_clear_len: assert property (p_clear_len) else $error("Clear ran too long or lost its bit.");

  property p_blank;
    @(posedge core_clk_i) disable iff (!resetn_i) (bright == dot_display_pkg::BRIGHT_BLANK && !testing) |=> digit_lit_o == 8'h00;
  endproperty
  a_blank: assert property (p_blank) else $error("Blank code left a digit lit.");

  property p_blink_wins;
    @(posedge core_clk_i) disable iff (!resetn_i) (blink_en && flash_phase && !testing) |=> digit_lit_o == 8'h00;
  endproperty
  a_blink_wins: assert property (p_blink_wins) else $error("Blink off phase left a digit lit.");

  property p_flash_ignored;
    @(posedge core_clk_i) disable iff (!resetn_i) (!flash_en && !blink_en && bright == 3'h0) |=> digit_lit_o == 8'hFF;
  endproperty
  a_flash_ignored: assert property (p_flash_ignored) else $error("Digit dark with flash and blink off.");

  property p_test_end;
    @(posedge core_clk_i) disable iff (!resetn_i)
      test_done |=> ptr_reg == 4'hF && flash_reg == 8'h00 && (ctrl_reg & ~dot_display_pkg::CW_PASS_MASK) == 8'h00;
  endproperty
  a_test_end: assert property (p_test_end) else $error("Self test end left state behind.");

  property p_test_len;
    @(posedge core_clk_i) disable iff (!resetn_i) testing |-> seq_cnt_reg <= TEST_LAST;
  endproperty
  a_test_len: assert property (p_test_len) else $error("Self test overran its length.");

  property p_read_drive;
    @(posedge core_clk_i) disable iff (!resetn_i) rd_cycle |=> data_oe_o ##0 (data_o == $past(rd_data));
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("Read cycle not driven on the bus.");

endmodule : dot_display_core

/* dv/host_model.sv */
`timescale 1ns/1ps
module host_model (
  // Host side of the bus
  input wire logic core_clk_i,
  output dot_display_pkg::host_bus_t bus_o,
  input wire logic [7:0] data_i
);
  initial bus_o = {4'hF, 5'h00, 8'h00};

  // Area is {select, A4, A3}; chip enable and data are held until the taking edge has passed.
  task automatic wr(input logic [2:0] area, input logic [2:0] idx, input logic [7:0] d);
    @(posedge core_clk_i);
    bus_o <= {1'b0, 1'b0, 1'b1, area[2], area[1:0], idx, d};
    @(posedge core_clk_i);
    bus_o.wr_n <= 1'b1;
    @(posedge core_clk_i);
    bus_o.ce_n <= 1'b1;
    bus_o.data <= ~d;
    @(posedge core_clk_i);
    // Let the edge's register updates settle before the caller samples outputs.
    #1;
  endtask : wr

  task automatic rd(input logic [2:0] area, input logic [2:0] idx, output logic [7:0] q);
    @(posedge core_clk_i);
    bus_o <= {1'b0, 1'b1, 1'b0, area[2], area[1:0], idx, bus_o.data};
    repeat (2) @(posedge core_clk_i);
    #1;
    q = data_i;
    @(posedge core_clk_i);
    bus_o.ce_n <= 1'b1;
    bus_o.rd_n <= 1'b1;
  endtask : rd
endmodule : host_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  // The ROM model returns its own address, so the expected sum is known here.
  function automatic logic [15:0] rom_sum();
    logic [15:0] s;
    s = 16'h0000;
    for (int a = 0; a < 128; a++) s = {s[14:0], s[15]} + 16'(a);
    return s;
  endfunction : rom_sum

  localparam logic [15:0] SUM = rom_sum();
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  dot_display_pkg::host_bus_t bus;
  logic [7:0] data_o, char_o, digit_lit, q;
  logic [6:0] rom_addr;
  logic [4:0] glyph_row;
  logic [2:0] brightness, char_sel = 3'h7, row_sel = 3'h0;
  logic [3:0] glyph_sel = 4'h5;
  logic data_oe, test_active, busy;
  int num_errors = 0;
  int cmp_count = 0;

  initial forever #25 core_clk = ~core_clk;

  host_model host_u (.core_clk_i(core_clk), .bus_o(bus), .data_i(data_o));

  dot_display_core #(.OSC_DIV(4), .FLASH_PERIOD_TICKS(16), .SELFTEST_TICKS(512), .CHECKSUM_EXPECT(SUM)) dut_u (
    .core_clk_i(core_clk), .resetn_i(resetn), .bus_i(bus), .data_o(data_o), .data_oe_o(data_oe),
    .clock_source_select_i(1'b1), .clk_pin_i(1'b0), .clk_pin_o(), .clk_pin_oe_o(),
    .rom_addr_o(rom_addr), .rom_data_i({1'b0, rom_addr}), .char_sel_i(char_sel), .char_o(char_o),
    .glyph_sel_i(glyph_sel), .glyph_row_sel_i(row_sel), .glyph_row_o(glyph_row), .brightness_o(brightness),
    .digit_lit_o(digit_lit), .test_active_o(test_active), .test_pattern_o(), .busy_o(busy));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // The host keeps off the bus until busy falls, and gives up after a bound.
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge core_clk);
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 4000) begin
      num_errors++;
      close_out();
    end
  endtask : wait_idle

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    wait_idle();
    check("char", 8'h20, char_o);
    host_u.rd(3'h6, 3'h0, q);
    check("ctrl", 8'h00, q);
  endtask : do_reset

  task automatic seen(input logic [7:0] ctrl, input logic [7:0] exp);
    logic [7:0] got;
    host_u.wr(3'h6, 3'h0, ctrl);
    got = ~exp;
    repeat (80) begin
      @(posedge core_clk);
      #1;
      if (digit_lit === exp) got = exp;
    end
    check("lit", exp, got);
  endtask : seen

  task automatic glyph_test();
    host_u.wr(3'h4, 3'h0, 8'hF5);
    host_u.rd(3'h4, 3'h0, q);
    check("ptr", 8'h05, q & 8'h0F);
    for (int r = 0; r < 7; r++) host_u.wr(3'h5, 3'(r), 8'(r * 5 + 227));
    for (int r = 0; r < 7; r++) begin
      row_sel <= 3'(r);
      repeat (3) @(posedge core_clk);
      check("row", 8'((r * 5 + 227) & 31), {3'h0, glyph_row});
    end
    host_u.rd(3'h5, 3'h6, q);
    check("row_rd", 8'h01, q & 8'h1F);
  endtask : glyph_test

  task automatic flash_test();
    host_u.wr(3'h3, 3'h3, 8'hFF);
    host_u.rd(3'h0, 3'h3, q);
    check("flag3", 8'h01, q & 8'h01);
    host_u.rd(3'h1, 3'h2, q);
    check("flag2", 8'h00, q & 8'h01);
    seen(8'h08, 8'hF7);
    seen(8'h18, 8'h00);
    seen(8'h07, 8'h00);
  endtask : flash_test

  task automatic ctrl_clear_test();
    host_u.wr(3'h6, 3'h0, 8'h2B);
    host_u.rd(3'h6, 3'h0, q);
    check("ctrl", 8'h0B, q);
    check("bright", 8'h03, {5'h00, brightness});
    host_u.wr(3'h7, 3'h7, 8'h41);
    check("char", 8'h41, char_o);
    host_u.wr(3'h6, 3'h0, 8'h83);
    wait_idle();
    host_u.rd(3'h6, 3'h0, q);
    check("ctrl", 8'h03, q);
    check("char", 8'h20, char_o);
    host_u.rd(3'h0, 3'h3, q);
    check("flag3", 8'h00, q & 8'h01);
  endtask : ctrl_clear_test

  task automatic self_test();
    do_reset();
    host_u.wr(3'h6, 3'h0, 8'h40);
    check("active", 8'h01, {7'h00, test_active});
    wait_idle();
    host_u.rd(3'h6, 3'h0, q);
    check("ctrl", 8'h20, q);
    host_u.rd(3'h4, 3'h0, q);
    check("ptr", 8'h0F, q & 8'h0F);
  endtask : self_test

  initial begin
    do_reset();
    glyph_test();
    flash_test();
    ctrl_clear_test();
    self_test();
    close_out();
  end
endmodule : testbench
